// ==== src/ebi_pkg.sv ====
/*
  constants, field layout, reset values and state codes of the external bus interface.
  assumes a single bus clock domain; shared by the top module and the testbench.
*/
package ebi_pkg;
  // wishbone byte addresses of the registers
  localparam logic [7:0] ADR_MODE = 8'h00; // bus_mode_control
  localparam logic [7:0] ADR_SELECT = 8'h04; // chip-select control
  localparam logic [7:0] ADR_STATUS = 8'h08; // read-only status

  // bus_mode_control field positions
  localparam int MODE_VIS = 0; // internal_visibility
  localparam int MODE_LOW_NOISE = 1; // 1 low noise, 0 high performance
  localparam int MODE_WAIT_SRC = 2; // wait_source_sel
  localparam int MODE_PIN_LO = 3; // wait_pin_cfg low bit
  localparam int MODE_PIN_HI = 4; // wait_pin_cfg high bit
  localparam int MODE_SPLIT_LO = 5; // region_split low bit
  localparam int MODE_SPLIT_HI = 6; // region_split high bit

  // chip-select control field positions
  localparam int SEL_UWAIT_LO = 0; // upper_wait_count
  localparam int SEL_UWAIT_HI = 1;
  localparam int SEL_UEN = 2; // upper enable
  localparam int SEL_UPOL = 3; // upper polarity, 1 active high
  localparam int SEL_LWAIT_LO = 4; // lower internal wait count
  localparam int SEL_LWAIT_HI = 5;
  localparam int SEL_LEN = 6; // lower enable
  localparam int SEL_LPOL = 7; // lower polarity, 1 active high

  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] SELECT_RESET = 8'h33; // both wait counts at 3

  // lower/upper region boundaries for region_split codes 0..3
  localparam logic [15:0] SPLIT_0 = 16'h1000;
  localparam logic [15:0] SPLIT_1 = 16'h4000;
  localparam logic [15:0] SPLIT_2 = 16'h8000;
  localparam logic [15:0] SPLIT_3 = 16'hC000;

  // wait_pin_cfg codes
  localparam logic [1:0] PIN_OFF = 2'h0;
  localparam logic [1:0] PIN_T4_LOWER = 2'h1;

  // phase lengths in bus-clock cycles
  localparam logic [2:0] FOURTH_CYCLES = 3'h3; // covers the two-flop pin delay
  localparam logic [2:0] DATA_CYCLES = 3'h3; // strobe hold after the waits

  // external cycle sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_FOURTH = 3'h2,
    ST_WAIT = 3'h3,
    ST_DATA = 3'h4
  } bus_state_e;
endpackage : ebi_pkg

// ==== src/pin_sync_if.sv ====
/*
  carrier between the top module and the data pin synchroniser.
  assumes both ends run on the same bus clock.
*/
`timescale 1ns/1ns
interface pin_sync_if;
  logic [7:0] raw; // data pins as they arrive
  logic [7:0] synced; // after two flip-flops
  modport top (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : pin_sync_if

// ==== src/data_pin_sync.sv ====
/*
  two-flop synchroniser for the external data pins.
  assumes raw pins are asynchronous to clk_sys; only stage two is read outside.
*/
`timescale 1ns/1ns
module data_pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pins in, synced out
  pin_sync_if.sync pins
);
  typedef struct packed {
    logic [7:0] stage1; // first flop, read only by stage2
    logic [7:0] stage2; // second flop, safe to use
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // shift the pins through two stages
  always_comb begin
    s_d = s_q;
    s_d.stage1 = pins.raw;
    s_d.stage2 = s_q.stage1;
  end

  // register the copy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins.synced = s_q.stage2;
endmodule : data_pin_sync

// ==== src/external_bus_interface.sv ====
/*
  external bus interface: runs cpu bus cycles onto a 16-bit address, 8-bit data bus
  with read/write strobes, two chip-selects and an external wait-count pin.
  assumes cpu requests on clk_sys, registers reached over classic wishbone.
*/
// Notes on behaviour
// RULE1 - low noise holds data lines between accesses
// RULE2 - read strobe runs external read into cpu
// RULE3 - write strobe sends cpu data outward
// RULE4 - strobes only external, unless visibility set
// RULE5 - two selectable chip-select regions in 64K
// RULE6 - upper region always holds the vectors
// RULE7 - internal addresses never make external selects (code: visible internal cycles in the upper region still assert upper_select)
// RULE8 - enabled select asserted across its region
// RULE9 - both wait counts reset to three
// RULE10 - upper waits from upper_wait_count field
// RULE11 - sample D2:0 end of fourth phase
// RULE12 - data bus undriven during fourth phase
// RULE13 - wait value latched only with lower_select
// RULE14 - outside buffer drives count only in phase
// RULE15 - external waits need source bit and pin
// RULE16 - pin config: off, phase+lower, phase
// RULE17 - wait decode frees low three data lines
// RULE18 - pin lower term always active low
// RULE19 - no lower select or phase pin internally
// RULE20 - visibility shows internal cycles on strobes
// RULE21 - mode bit: 1 low noise, 0 fast
// RULE22 - source bit: 1 external, 0 internal waits
// RULE23 - split codes give boundaries 1000..C000
// RULE24 - per-select enable and polarity bits
// RULE25 - stall cpu for external cycles only
// RULE26 - low noise holds address between accesses
// RULE27 - each wait adds one bus-clock period
`timescale 1ns/1ns
module external_bus_interface (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu bus side
  input wire logic cpu_req,
  input wire logic cpu_write,
  input wire logic cpu_internal,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_done,
  output logic cpu_stall_request,
  // external address and data
  output logic [15:0] ext_addr,
  input wire logic [7:0] ext_data_i,
  output logic [7:0] ext_data_o,
  output logic [7:0] ext_data_oe,
  // external control
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic upper_select,
  output logic lower_select,
  output logic wait_phase_clock_o,
  output logic wait_phase_clock_oe
);
  typedef struct packed {
    ebi_pkg::bus_state_e st; // sequencer state
    logic [2:0] phase; // cycles left in a phase
    logic [2:0] waits; // wait states left
    logic wr; // cycle is a write
    logic upper; // address in upper region
    logic lower; // address in lower region, external only
    logic vis; // internal cycle shown by visibility
    logic [15:0] addr; // address pins
    logic [7:0] dout; // data pins out
    logic [7:0] rdata; // read data to cpu
    logic done; // end-of-cycle pulse
    logic [7:0] mode; // bus_mode_control
    logic [7:0] csel; // chip-select control
    logic ack; // wishbone ack
    logic [31:0] wbdat; // wishbone read data
    logic [2:0] last_wait; // wait count of last cycle
  } ebi_s;

  ebi_s s_q;
  ebi_s s_d;

  pin_sync_if sync_bus ();
  logic [7:0] pins_synced; // data pins after two flops
  logic [15:0] boundary; // start of upper region
  logic hit_upper; // request address is upper region
  logic ext_wait_on; // external wait decoding in force
  logic [2:0] wait_pick; // wait count chosen at phase end
  logic wb_take; // wishbone request this cycle
  logic take_req; // cpu request accepted
  logic active; // a bus cycle runs, external or visible internal
  logic fourth; // fourth phase shown on the pin
  logic float_bus; // data pins must be released
  logic upper_act; // upper select asserted, logical
  logic lower_act; // lower select asserted, logical

  data_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pins(sync_bus.sync)
  );

  assign sync_bus.raw = ext_data_i;
  assign pins_synced = sync_bus.synced;

  // region boundary from the split code
  always_comb begin
    unique case (s_q.mode[ebi_pkg::MODE_SPLIT_HI:ebi_pkg::MODE_SPLIT_LO])
      2'h0: boundary = ebi_pkg::SPLIT_0; // [RULE23]
      2'h1: boundary = ebi_pkg::SPLIT_1; // [RULE23]
      2'h2: boundary = ebi_pkg::SPLIT_2; // [RULE23]
      2'h3: boundary = ebi_pkg::SPLIT_3; // [RULE23]
    endcase
  end

  // upper runs to the top, so vectors always fall in it
  assign hit_upper = (cpu_addr >= boundary); // [RULE5] [RULE6]

  // external wait decoding on with source bit set and pin config not off
  assign ext_wait_on = s_q.mode[ebi_pkg::MODE_WAIT_SRC]
    & (s_q.mode[ebi_pkg::MODE_PIN_HI:ebi_pkg::MODE_PIN_LO] != ebi_pkg::PIN_OFF); // [RULE15] [RULE22]

  assign wb_take = wb_cyc_i & wb_stb_i & ~s_q.ack;

  // accept external requests, or internal ones when visible
  assign take_req = cpu_req & (~cpu_internal | s_q.mode[ebi_pkg::MODE_VIS]); // [RULE4] [RULE20]

  // wait count at the end of the fourth phase
  always_comb begin
    if (s_q.vis) begin
      wait_pick = 3'h0; // internal cycles never wait
    end else if (s_q.upper) begin
      wait_pick = {1'b0, s_q.csel[ebi_pkg::SEL_UWAIT_HI:ebi_pkg::SEL_UWAIT_LO]}; // [RULE10]
    end else if (ext_wait_on & s_q.csel[ebi_pkg::SEL_LEN]) begin
      wait_pick = pins_synced[2:0]; // [RULE11] [RULE13]
    end else begin
      wait_pick = {1'b0, s_q.csel[ebi_pkg::SEL_LWAIT_HI:ebi_pkg::SEL_LWAIT_LO]};
    end
  end

  // next state of registers, sequencer and pins
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.ack = wb_take;
    // register access
    if (wb_take) begin
      if (wb_we_i & wb_sel_i[0]) begin
        if (wb_adr_i == ebi_pkg::ADR_MODE) begin
          s_d.mode = wb_dat_i[7:0]; // [RULE21] [RULE22]
        end else if (wb_adr_i == ebi_pkg::ADR_SELECT) begin
          s_d.csel = wb_dat_i[7:0]; // [RULE24]
        end
      end
      if (wb_adr_i == ebi_pkg::ADR_MODE) begin
        s_d.wbdat = {24'h000000, s_q.mode};
      end else if (wb_adr_i == ebi_pkg::ADR_SELECT) begin
        s_d.wbdat = {24'h000000, s_q.csel};
      end else if (wb_adr_i == ebi_pkg::ADR_STATUS) begin
        s_d.wbdat = {24'h000000, 1'b0, s_q.last_wait, 1'b0, s_q.st};
      end else begin
        s_d.wbdat = 32'h00000000; // unmapped reads zero
      end
    end
    // sequencer
    unique case (s_q.st)
      ebi_pkg::ST_IDLE: begin
        // high performance lets pins follow the cpu bus
        if (!s_q.mode[ebi_pkg::MODE_LOW_NOISE]) begin
          s_d.addr = cpu_addr; // [RULE21]
          s_d.dout = cpu_wdata; // [RULE21]
        end
        if (take_req) begin
          s_d.st = ebi_pkg::ST_SETUP;
          s_d.addr = cpu_addr; // [RULE26]
          s_d.wr = cpu_write;
          s_d.vis = cpu_internal; // [RULE20]
          s_d.upper = hit_upper; // [RULE8]
          s_d.lower = ~hit_upper & ~cpu_internal; // [RULE7] [RULE19]
          if (cpu_write | cpu_internal) begin
            s_d.dout = cpu_wdata; // [RULE3] [RULE1]
          end
        end
      end
      ebi_pkg::ST_SETUP: begin
        s_d.st = ebi_pkg::ST_FOURTH;
        s_d.phase = ebi_pkg::FOURTH_CYCLES - 3'h1;
      end
      ebi_pkg::ST_FOURTH: begin
        if (s_q.phase != 3'h0) begin
          s_d.phase = s_q.phase - 3'h1;
        end else begin
          s_d.last_wait = wait_pick;
          s_d.waits = wait_pick;
          s_d.phase = ebi_pkg::DATA_CYCLES - 3'h1;
          s_d.st = (wait_pick != 3'h0) ? ebi_pkg::ST_WAIT : ebi_pkg::ST_DATA;
        end
      end
      ebi_pkg::ST_WAIT: begin
        // one bus-clock period per wait state
        if (s_q.waits == 3'h1) begin
          s_d.st = ebi_pkg::ST_DATA; // [RULE27]
        end
        s_d.waits = s_q.waits - 3'h1; // [RULE27]
      end
      ebi_pkg::ST_DATA: begin
        if (s_q.phase != 3'h0) begin
          s_d.phase = s_q.phase - 3'h1;
        end else begin
          s_d.st = ebi_pkg::ST_IDLE;
          s_d.done = ~s_q.vis;
          if (!s_q.wr && !s_q.vis) begin
            s_d.rdata = pins_synced; // [RULE2]
          end
        end
      end
      default: begin
        s_d.st = ebi_pkg::ST_IDLE; // illegal code recovers
      end
    endcase
  end

  // register the copy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ebi_pkg::ST_IDLE;
      s_q.mode <= ebi_pkg::MODE_RESET;
      s_q.csel <= ebi_pkg::SELECT_RESET; // [RULE9]
    end else begin
      s_q <= s_d;
    end
  end

  // cycle phase decode
  assign active = (s_q.st != ebi_pkg::ST_IDLE);
  assign fourth = (s_q.st == ebi_pkg::ST_FOURTH) & ~s_q.vis; // [RULE19]
  // release data for reads and the fourth phase of external cycles
  assign float_bus = active & ~s_q.vis & ((s_q.st == ebi_pkg::ST_FOURTH) | ~s_q.wr); // [RULE12] [RULE2]

  // strobes, active low
  assign read_strobe_n = ~(active & ~s_q.wr); // [RULE2] [RULE4]
  assign write_strobe_n = ~(active & s_q.wr); // [RULE3] [RULE4]

  // chip-selects with enable and polarity
  assign upper_act = active & s_q.upper & s_q.csel[ebi_pkg::SEL_UEN]; // [RULE8] [RULE24]
  assign lower_act = active & s_q.lower & s_q.csel[ebi_pkg::SEL_LEN]; // [RULE7] [RULE8]
  assign upper_select = s_q.csel[ebi_pkg::SEL_UPOL] ? upper_act : ~upper_act; // [RULE24]
  assign lower_select = s_q.csel[ebi_pkg::SEL_LPOL] ? lower_act : ~lower_act; // [RULE24]

  // wait-phase pin, active low in both driven modes
  always_comb begin
    unique case (s_q.mode[ebi_pkg::MODE_PIN_HI:ebi_pkg::MODE_PIN_LO])
      ebi_pkg::PIN_OFF: begin
        wait_phase_clock_o = 1'b1;
        wait_phase_clock_oe = 1'b0; // [RULE16]
      end
      ebi_pkg::PIN_T4_LOWER: begin
        // lower term taken active low whatever its pin polarity
        wait_phase_clock_o = ~(fourth & lower_act); // [RULE16] [RULE18] [RULE14]
        wait_phase_clock_oe = 1'b1;
      end
      default: begin
        wait_phase_clock_o = ~fourth; // [RULE16]
        wait_phase_clock_oe = 1'b1;
      end
    endcase
  end

  // data pin enables; held value stays driven, low bits freed for wait decode
  always_comb begin
    ext_data_oe = {8{~float_bus}}; // [RULE1] [RULE12]
    if (ext_wait_on) begin
      ext_data_oe[2:0] = {3{(s_q.st == ebi_pkg::ST_DATA) & (s_q.wr | s_q.vis)}}; // [RULE17]
    end
  end

  assign ext_addr = s_q.addr; // [RULE26]
  assign ext_data_o = s_q.dout; // [RULE1]
  assign cpu_rdata = s_q.rdata;
  assign cpu_done = s_q.done;
  assign cpu_stall_request = active & ~s_q.vis; // [RULE25]
  assign wb_dat_o = s_q.wbdat;
  assign wb_ack_o = s_q.ack;
endmodule : external_bus_interface

// ==== verification/ebi_sva.sv ====
/* checker on the external bus interface top ports, bound at the foot.
   assumes one bus clock and a synchronous active-low reset. */
`timescale 1ns/1ns
module ebi_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // cpu side
  input wire logic cpu_req,
  input wire logic cpu_internal,
  input wire logic cpu_done,
  input wire logic cpu_stall_request,
  // external pins
  input wire logic [7:0] ext_data_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic wait_phase_clock_o,
  input wire logic wait_phase_clock_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic pin_low = wait_phase_clock_oe && !wait_phase_clock_o; // phase pin asserted
  wire logic idle = read_strobe_n && write_strobe_n && !cpu_stall_request; // nothing on the bus
  property p_one_strobe; cpu_stall_request |-> read_strobe_n != write_strobe_n; endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("stall without one strobe");
  property p_quiet_inside; cpu_req && cpu_internal && idle |=> !cpu_stall_request; endproperty
  a_quiet_inside: assert property (p_quiet_inside) else $error("internal stalled");
  property p_stall_len; $rose(cpu_stall_request) |-> cpu_stall_request[*7] ##[1:8] !cpu_stall_request; endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length");
  property p_done_end; $fell(cpu_stall_request) |-> cpu_done; endproperty
  a_done_end: assert property (p_done_end) else $error("no done at stall end");
  property p_pin_idle; !cpu_stall_request |-> !pin_low; endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("phase pin outside cycle");
  property p_phase_float; pin_low |-> ext_data_oe == 8'h00; endproperty
  a_phase_float: assert property (p_phase_float) else $error("data driven in phase");
  property p_phase_len; $rose(pin_low) |-> pin_low[*3] ##1 !pin_low; endproperty
  a_phase_len: assert property (p_phase_len) else $error("phase length");
  property p_read_float; !read_strobe_n && cpu_stall_request |-> ext_data_oe == 8'h00; endproperty
  a_read_float: assert property (p_read_float) else $error("data driven on read");
endmodule : ebi_sva
bind external_bus_interface ebi_sva u_ebi_sva (.clk_sys, .rst_n, .cpu_req, .cpu_internal, .cpu_done,
  .cpu_stall_request, .ext_data_oe, .read_strobe_n, .write_strobe_n, .wait_phase_clock_o, .wait_phase_clock_oe);

// ==== verification/ext_mem_model.sv ====
/* byte memory with a wait-count decoder on the far side of the bus.
   assumes it resolves the shared data lines from the block's enables. */
`timescale 1ns/1ns
module ext_mem_model (
  // clock
  input wire logic clk_sys,
  // bus from the block
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_data_o,
  input wire logic [7:0] ext_data_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic wait_phase_clock_o,
  input wire logic wait_phase_clock_oe,
  // count to hand back, resolved lines
  input wire logic [2:0] wait_val,
  output logic [7:0] ext_data_i
);
  logic [7:0] mem [256]; // byte store by low address
  logic [7:0] drv; // model's own level
  logic [7:0] flt_q = 8'h5A; // released lines toggle
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
  // store driven write data, toggle the released level
  always @(posedge clk_sys) begin
    flt_q <= ~flt_q;
    if (!write_strobe_n && ext_data_oe == 8'hFF) mem[ext_addr[7:0]] <= ext_data_o;
  end
  // count only inside the pin window, memory on reads
  always_comb begin
    if (wait_phase_clock_oe && !wait_phase_clock_o) drv = {flt_q[7:3], wait_val};
    else if (!read_strobe_n) drv = mem[ext_addr[7:0]];
    else drv = flt_q;
    for (int b = 0; b < 8; b++) ext_data_i[b] = ext_data_oe[b] ? ext_data_o[b] : drv[b];
  end
endmodule : ext_mem_model

// ==== verification/testbench.sv ====
/* self-checking bench: wishbone register tasks, cpu cycle task, memory model.
   assumes the block and model share clk_sys at 10 MHz. */
`timescale 1ns/1ns
module testbench;
  // clock, reset, wishbone
  logic clk_sys = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  // cpu side and pins
  logic cpu_req = 1'b0, cpu_write = 1'b0, cpu_internal = 1'b0, cpu_done, cpu_stall_request, dn;
  logic [15:0] cpu_addr = 16'h0, ext_addr;
  logic [15:0] bnd [4] = '{16'h1000, 16'h4000, 16'h8000, 16'hC000}; // split boundaries
  logic [7:0] cpu_wdata = 8'h00, cpu_rdata, ext_data_i, ext_data_o, ext_data_oe, rb;
  logic read_strobe_n, write_strobe_n, upper_select, lower_select, wait_phase_clock_o, wait_phase_clock_oe;
  logic [2:0] wait_val = 3'h5; // count the decoder hands back
  // tallies
  int num_errors = 0, n_compared = 0, k, n_up, n_lo, n_pin, n_stb, n_stl;
  always #50 clk_sys = ~clk_sys;
  external_bus_interface u_external_bus_interface (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_req, .cpu_write, .cpu_internal, .cpu_addr, .cpu_wdata,
    .cpu_rdata, .cpu_done, .cpu_stall_request, .ext_addr, .ext_data_i, .ext_data_o, .ext_data_oe,
    .read_strobe_n, .write_strobe_n, .upper_select, .lower_select, .wait_phase_clock_o, .wait_phase_clock_oe);
  ext_mem_model u_ext_mem_model (.clk_sys, .ext_addr, .ext_data_o, .ext_data_oe, .read_strobe_n,
    .write_strobe_n, .wait_phase_clock_o, .wait_phase_clock_oe, .wait_val, .ext_data_i);
  // verdict and end of run
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic wishbone cycle, ack sampled before its edge
  task automatic wb_io(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(negedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) num_errors++;
    if (n >= 20) finish_test();
  endtask : wb_io
  // both registers, mode first then select
  task automatic set_regs(input logic [7:0] m, input logic [7:0] s);
    wb_io(1'b1, ebi_pkg::ADR_MODE, m);
    wb_io(1'b1, ebi_pkg::ADR_SELECT, s);
  endtask : set_regs
  // one cpu request, held until stall shows, internal ones for one cycle only; tallies each cycle
  task automatic cpu_io(input logic w, input logic i, input logic [15:0] a, input logic [7:0] d);
    {k, n_up, n_lo, n_pin, n_stb, n_stl} = '0;
    @(posedge clk_sys);
    cpu_req <= 1'b1;
    cpu_write <= w;
    cpu_internal <= i;
    cpu_addr <= a;
    cpu_wdata <= d;
    do begin
      @(negedge clk_sys);
      k++;
      n_up += int'(upper_select === 1'b1);
      n_lo += int'(lower_select === 1'b1);
      n_pin += int'(wait_phase_clock_oe === 1'b1 && wait_phase_clock_o === 1'b0);
      n_stb += int'(read_strobe_n === 1'b0 || write_strobe_n === 1'b0);
      n_stl += int'(cpu_stall_request === 1'b1);
      dn = cpu_done === 1'b1;
      if (dn) rb = cpu_rdata;
      @(posedge clk_sys);
      if (i || n_stl > 0) cpu_req <= 1'b0;
    end while (!dn && k < 30);
    if (!i && !dn) num_errors++;
    if (!i && !dn) finish_test();
  endtask : cpu_io
  // cycle length, stall window and which select
  task automatic expect_cyc(input int w, input bit up);
    check(k, 9 + w);
    check(n_stl, 7 + w);
    check(n_stb, 7 + w);
    check(up ? n_up : n_lo, 7 + w);
    check(up ? n_lo : n_up, 0);
  endtask : expect_cyc
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb_io(1'b0, ebi_pkg::ADR_SELECT, 8'h00);
    check({rd[5:4], rd[1:0]}, 4'hF);
    wb_io(1'b0, 8'h0C, 8'h00);
    check(rd, 32'h0);
    // each split, upper waits rising, lower falling
    for (int s = 0; s < 4; s++) begin
      set_regs({1'b0, 2'(s), 5'h00}, 8'hCC | 8'((3 - s) << 4) | 8'(s));
      cpu_io(1'b0, 1'b0, bnd[s], 8'h00);
      expect_cyc(s, 1'b1);
      check(rb, 8'h3C);
      cpu_io(1'b0, 1'b0, bnd[s] - 16'h1, 8'h00);
      expect_cyc(3 - s, 1'b0);
    end
    cpu_io(1'b1, 1'b0, 16'h0123, 8'hA5);
    cpu_io(1'b0, 1'b0, 16'h0123, 8'h00);
    check(rb, 8'hA5);
    // decoder counts 0 to 7, then an upper cycle
    set_regs(8'h0C, 8'hDE);
    for (int w = 0; w < 8; w++) begin
      wait_val <= 3'(w);
      cpu_io(1'b0, 1'b0, 16'h0040, 8'h00);
      expect_cyc(w, 1'b0);
      check(n_pin, 3);
    end
    cpu_io(1'b0, 1'b0, 16'hFFFF, 8'h00);
    expect_cyc(2, 1'b1);
    wb_io(1'b1, ebi_pkg::ADR_MODE, 8'h08);
    cpu_io(1'b0, 1'b0, 16'h0040, 8'h00);
    check(k, 10);
    // every pin code with external source
    for (int p = 0; p < 4; p++) begin
      wb_io(1'b1, ebi_pkg::ADR_MODE, {3'h0, 2'(p), 3'h4});
      cpu_io(1'b0, 1'b0, 16'h0040, 8'h00);
      check(k, p == 0 ? 10 : 16);
      check(n_pin, p == 0 ? 0 : 3);
      cpu_io(1'b0, 1'b0, 16'hFFFF, 8'h00);
      check(n_pin, p > 1 ? 3 : 0);
    end
    // lower active low, then lower disabled and an unseen internal cycle
    set_regs(8'h00, 8'h4C);
    cpu_io(1'b0, 1'b0, 16'h0040, 8'h00);
    check(n_lo, 2);
    wb_io(1'b1, ebi_pkg::ADR_SELECT, 8'h8C);
    cpu_io(1'b0, 1'b1, 16'h0040, 8'h00);
    check(n_stb + n_stl + n_lo + n_up, 0);
    // visible internal cycles
    set_regs(8'h09, 8'hCC);
    cpu_io(1'b0, 1'b1, 16'hFFFF, 8'h00);
    check(n_stb != 0 && n_up != 0 && n_stl == 0, 1'b1);
    cpu_io(1'b0, 1'b1, 16'h0040, 8'h00);
    check(n_lo + n_pin, 0);
    // low noise holds pins through an internal cycle
    set_regs(8'h02, 8'hCC);
    cpu_io(1'b1, 1'b0, 16'h0055, 8'h96);
    repeat (2) begin
      @(negedge clk_sys);
      check({ext_data_oe, ext_data_o, ext_addr}, 32'hFF96_0055);
      cpu_io(1'b0, 1'b1, 16'h1234, 8'h11);
    end
    wb_io(1'b1, ebi_pkg::ADR_MODE, 8'h00);
    @(negedge clk_sys);
    check(ext_addr, 16'h1234);
    finish_test();
  end
endmodule : testbench
